/* File: src/qbs_sram_ports.v */
// Burst-of-two SRAM with separate read and write ports, double data rate.
// Assumes SYS_CLK_I runs far faster than the pin clocks; every pin is
// oversampled through two flip-flops and clock pins are edge-detected.
`include "qbs_map.vh"
`default_nettype none

module qbs_sram_ports #(
    parameter ARRAY_AW = `QBS_ADDR_W
) (
    // System
    input  wire                      SYS_CLK_I,
    input  wire                      SYS_RST_I,
    // Clock pins
    input  wire                      SYS_IN_POS_I,
    input  wire                      SYS_IN_NEG_I,
    input  wire                      OUT_REF_POS_I,
    input  wire                      OUT_REF_NEG_I,
    input  wire                      DLL_DISABLE_N_I,
    // Request pins
    input  wire [`QBS_ADDR_W-1:0]    ADDR_I,
    input  wire                      READ_PORT_SELECT_N_I,
    input  wire                      WRITE_PORT_SELECT_N_I,
    input  wire [`QBS_BWS_W-1:0]     BYTE_WRITE_SELECT_N_I,
    input  wire [`QBS_WORD_W-1:0]    WR_DATA_I,
    // Read data pins
    output reg  [`QBS_WORD_W-1:0]    RD_DATA_O,
    output reg                       RD_DATA_OE_O,
    output reg                       ECHO_POS_OUT_O,
    output reg                       ECHO_NEG_OUT_O,
    // Status
    output reg                       DLL_LOCKED_O,
    output reg                       IMP_UPDATE_O,
    output wire                      RD_FIFO_READY_O
);
    // ==============================================================
    // Local constants
    localparam PIN_W = 7 + `QBS_BWS_W + `QBS_ADDR_W + `QBS_WORD_W;

    localparam [1:0] OS_IDLE  = 2'b00;
    localparam [1:0] OS_WORD1 = 2'b01;
    localparam [1:0] OS_HOLD  = 2'b10;

    localparam [`QBS_GAP_W:0]   STOP_CYC  = `QBS_DLL_STOP_CYC;
    localparam [10:0]           LOCK_LAST = `QBS_DLL_LOCK_CYC - 1;
    localparam [10:0]           IMP_LAST  = `QBS_IMP_UPD_CYC - 1;
    localparam [1:0]            STRAP_CNT = `QBS_STRAP_WAIT;

    // ==============================================================
    // Byte select decode, used for both halves of a burst
    function [`QBS_WORD_W-1:0] bws_mask;
        input [`QBS_BWS_W-1:0] bws_n;
        integer b;
        begin
            bws_mask = {`QBS_WORD_W{1'b0}};
            for (b = 0; b < `QBS_BWS_W; b = b + 1) begin
                bws_mask[b*`QBS_BYTE_W +: `QBS_BYTE_W] = {`QBS_BYTE_W{~bws_n[b]}};
            end
        end
    endfunction

    // ==============================================================
    // Pin synchronisers
    wire [PIN_W-1:0] pin_raw;
    reg  [PIN_W-1:0] sync1_q;
    reg  [PIN_W-1:0] sync2_q;

    assign pin_raw = {SYS_IN_POS_I, SYS_IN_NEG_I, OUT_REF_POS_I, OUT_REF_NEG_I,
                      DLL_DISABLE_N_I, READ_PORT_SELECT_N_I, WRITE_PORT_SELECT_N_I,
                      BYTE_WRITE_SELECT_N_I, ADDR_I, WR_DATA_I};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
            always @(posedge SYS_CLK_I) begin
                if (SYS_RST_I) begin
                    sync1_q[gi] <= `QBS_RST_SYNC;
                    sync2_q[gi] <= `QBS_RST_SYNC;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire                     k_s     = sync2_q[PIN_W-1];
    wire                     kn_s    = sync2_q[PIN_W-2];
    wire                     c_s     = sync2_q[PIN_W-3];
    wire                     cn_s    = sync2_q[PIN_W-4];
    wire                     dll_en  = sync2_q[PIN_W-5];
    wire                     rps_n_s = sync2_q[PIN_W-6];
    wire                     wps_n_s = sync2_q[PIN_W-7];
    wire [`QBS_BWS_W-1:0]    bws_n_s = sync2_q[`QBS_ADDR_W+`QBS_WORD_W +: `QBS_BWS_W];
    wire [`QBS_ADDR_W-1:0]   addr_s  = sync2_q[`QBS_WORD_W +: `QBS_ADDR_W];
    wire [`QBS_WORD_W-1:0]   d_s     = sync2_q[`QBS_WORD_W-1:0];

    // ==============================================================
    // Clock strap and edge detection
    // Edges stay masked until the synchronisers have filled, so no
    // false rise appears right after reset.
    reg  [1:0] strap_cnt_q;
    reg        strap_done_q;
    reg        single_q;
    reg  [3:0] clk_prev_q;
    wire [3:0] clk_now = {k_s, kn_s, c_s, cn_s};
    wire [3:0] clk_rise = clk_now & ~clk_prev_q & {4{strap_done_q}};
    wire       k_rise  = clk_rise[3];
    wire       kn_rise = clk_rise[2];
    wire       out_pos_rise;
    wire       out_neg_rise;

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            single_q     <= 1'b0;
            clk_prev_q   <= 4'hf;
        end else begin
            clk_prev_q <= clk_now;
            if (!strap_done_q) begin
                if (strap_cnt_q == STRAP_CNT) begin
                    strap_done_q <= 1'b1;
                    single_q     <= c_s & cn_s;
                end else begin
                    strap_cnt_q <= strap_cnt_q + 2'h1;
                end
            end
        end
    end

    // Strap is sampled once after each reset, so the edge source never moves until the next reset
    assign out_pos_rise = single_q ? k_rise  : clk_rise[1];
    assign out_neg_rise = single_q ? kn_rise : clk_rise[0];

    // ==============================================================
    // Memory array: one location holds both words of a burst
    reg  [`QBS_BURST_W-1:0] mem [0:(1<<ARRAY_AW)-1];

    // ==============================================================
    // Write port
    reg                     wr_pend_q;
    reg  [`QBS_WORD_W-1:0]  wr_lo_q;
    reg  [`QBS_WORD_W-1:0]  wr_lo_mask_q;
    wire                    commit;
    wire [ARRAY_AW-1:0]     commit_idx;
    wire [`QBS_BURST_W-1:0] commit_data;
    wire [`QBS_BURST_W-1:0] commit_mask;
    wire [`QBS_BURST_W-1:0] commit_merged;

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            wr_pend_q    <= 1'b0;
            wr_lo_q      <= {`QBS_WORD_W{1'b0}};
            wr_lo_mask_q <= {`QBS_WORD_W{1'b0}};
        end else if (k_rise) begin
            wr_pend_q <= ~wps_n_s;
            if (!wps_n_s) begin
                wr_lo_q      <= d_s;
                wr_lo_mask_q <= bws_mask(bws_n_s);
            end
        end else if (kn_rise) begin
            wr_pend_q <= 1'b0;
        end
    end

    // Second word, its byte selects and the address all come on the
    // negative input edge; the pending write always finishes here.
    assign commit        = kn_rise & wr_pend_q;
    assign commit_idx    = addr_s[ARRAY_AW-1:0];
    assign commit_data   = {d_s, wr_lo_q};
    assign commit_mask   = {bws_mask(bws_n_s), wr_lo_mask_q};
    assign commit_merged = (mem[commit_idx] & ~commit_mask) | (commit_data & commit_mask);

    always @(posedge SYS_CLK_I) begin
        if (commit) begin
            mem[commit_idx] <= commit_merged;
        end
    end

    // ==============================================================
    // Read port
    // The array is read on the negative edge after the request, after
    // any write begun on the same or earlier positive edge has landed.
    reg                     rd_pend_q;
    reg  [ARRAY_AW-1:0]     rd_idx_q;
    wire                    fetch;
    wire [`QBS_BURST_W-1:0] fetch_data;
    wire                    fifo_in_ready;
    wire                    fifo_out_valid;
    wire                    fifo_out_ready;
    wire [`QBS_BURST_W-1:0] fifo_out_data;

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            rd_pend_q <= 1'b0;
            rd_idx_q  <= {ARRAY_AW{1'b0}};
        end else if (k_rise) begin
            rd_pend_q <= ~rps_n_s;
            if (!rps_n_s) begin
                rd_idx_q <= addr_s[ARRAY_AW-1:0];
            end
        end else if (kn_rise) begin
            rd_pend_q <= 1'b0;
        end
    end

    assign fetch      = kn_rise & rd_pend_q;
    assign fetch_data = (commit && (commit_idx == rd_idx_q)) ? commit_merged : mem[rd_idx_q];

    // A full buffer drops the fetch; RD_FIFO_READY_O shows the stall
    qbs_fifo #(
        .W     (`QBS_BURST_W),
        .DEPTH (`QBS_FIFO_DEPTH),
        .AW    (`QBS_FIFO_AW)
    ) u_rd_fifo (
        .clk_i       (SYS_CLK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (fetch),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fetch_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign RD_FIFO_READY_O = fifo_in_ready;

    // ==============================================================
    // Output sequencer
    // A burst may launch only once a positive input edge has passed
    // since it was fetched; skew between input and output clocks then
    // cannot pull the first word a cycle early.
    reg  [1:0]             os_state_q;
    reg  [`QBS_WORD_W-1:0] rd_hi_q;
    reg                    arm_q;
    wire                   armed;
    wire                   first_edge;
    wire                   second_edge;
    wire                   any_out_edge;
    wire                   launch;

    assign armed        = fifo_out_valid & (arm_q | k_rise);
    assign first_edge   = dll_en ? out_neg_rise : out_pos_rise;
    assign second_edge  = dll_en ? out_pos_rise : out_neg_rise;
    assign any_out_edge = out_pos_rise | out_neg_rise;
    assign launch       = armed & first_edge & (os_state_q != OS_WORD1);
    assign fifo_out_ready = launch;

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            arm_q <= 1'b0;
        end else if (launch) begin
            arm_q <= 1'b0;
        end else if (k_rise && fifo_out_valid) begin
            arm_q <= 1'b1;
        end
    end

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            os_state_q   <= OS_IDLE;
            RD_DATA_O    <= {`QBS_WORD_W{1'b0}};
            RD_DATA_OE_O <= `QBS_RST_OE;
            rd_hi_q      <= {`QBS_WORD_W{1'b0}};
        end else begin
            case (os_state_q)
                OS_IDLE: begin
                    if (launch) begin
                        RD_DATA_O    <= fifo_out_data[`QBS_WORD0_LSB +: `QBS_WORD_W];
                        rd_hi_q      <= fifo_out_data[`QBS_WORD1_LSB +: `QBS_WORD_W];
                        RD_DATA_OE_O <= 1'b1;
                        os_state_q   <= OS_WORD1;
                    end
                end
                OS_WORD1: begin
                    if (second_edge) begin
                        RD_DATA_O  <= rd_hi_q;
                        os_state_q <= OS_HOLD;
                    end
                end
                OS_HOLD: begin
                    if (launch) begin
                        // Back-to-back burst replaces the float slot
                        RD_DATA_O    <= fifo_out_data[`QBS_WORD0_LSB +: `QBS_WORD_W];
                        rd_hi_q      <= fifo_out_data[`QBS_WORD1_LSB +: `QBS_WORD_W];
                        os_state_q   <= OS_WORD1;
                    end else if (any_out_edge) begin
                        RD_DATA_OE_O <= 1'b0;
                        os_state_q   <= OS_IDLE;
                    end
                end
                default: begin
                    RD_DATA_OE_O <= 1'b0;
                    os_state_q   <= OS_IDLE;
                end
            endcase
        end
    end

    // ==============================================================
    // Echo clocks
    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            ECHO_POS_OUT_O <= 1'b0;
            ECHO_NEG_OUT_O <= 1'b0;
        end else if (strap_done_q) begin
            ECHO_POS_OUT_O <= single_q ? k_s  : c_s;
            ECHO_NEG_OUT_O <= single_q ? kn_s : cn_s;
        end
    end

    // ==============================================================
    // DLL lock model
    // A stop is a gap longer than the previous period plus the minimum
    // stop time; the count starts saturated, so the time from reset to the
    // first rise is taken as a full-scale period that no gap can exceed. The 120 MHz floor is not checked.
    reg  [`QBS_GAP_W-1:0] gap_cnt_q;
    reg  [`QBS_GAP_W-1:0] last_gap_q;
    reg  [10:0]           lock_cnt_q;
    wire                  clk_stopped;

    assign clk_stopped = (last_gap_q != {`QBS_GAP_W{1'b0}}) &&
                         ({1'b0, gap_cnt_q} > ({1'b0, last_gap_q} + STOP_CYC));

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            gap_cnt_q  <= {`QBS_GAP_W{1'b1}};
            last_gap_q <= {`QBS_GAP_W{1'b0}};
        end else if (k_rise) begin
            last_gap_q <= gap_cnt_q;
            gap_cnt_q  <= {`QBS_GAP_W{1'b0}};
        end else if (gap_cnt_q != {`QBS_GAP_W{1'b1}}) begin
            gap_cnt_q <= gap_cnt_q + {{(`QBS_GAP_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            lock_cnt_q   <= 11'h0;
            DLL_LOCKED_O <= 1'b0;
        end else if (!dll_en || clk_stopped) begin
            lock_cnt_q   <= 11'h0;
            DLL_LOCKED_O <= 1'b0;
        end else if (k_rise && !DLL_LOCKED_O) begin
            if (lock_cnt_q == LOCK_LAST) begin
                DLL_LOCKED_O <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 11'h1;
            end
        end
    end

    // ==============================================================
    // Impedance update cadence
    reg [10:0] imp_cnt_q;

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            imp_cnt_q    <= 11'h0;
            IMP_UPDATE_O <= 1'b0;
        end else begin
            IMP_UPDATE_O <= 1'b0;
            if (k_rise) begin
                if (imp_cnt_q == IMP_LAST) begin
                    imp_cnt_q    <= 11'h0;
                    IMP_UPDATE_O <= 1'b1;
                end else begin
                    imp_cnt_q <= imp_cnt_q + 11'h1;
                end
            end
        end
    end
endmodule // qbs_sram_ports

`default_nettype wire

/* File: src/qbs_map.vh */
// Constants for the burst-of-two dual-port SRAM model.
// Assumes a 100 MHz system clock that oversamples every device pin.
`ifndef QBS_MAP_VH
`define QBS_MAP_VH

// ==================================================================
// Data layout
`define QBS_WORD_W          18
`define QBS_BURST_W         36
`define QBS_BYTE_W          9
`define QBS_BWS_W           2
`define QBS_ADDR_W          21
`define QBS_WORD0_LSB       0
`define QBS_WORD1_LSB       18

// ==================================================================
// Read data buffer
`define QBS_FIFO_DEPTH      32
`define QBS_FIFO_AW         5

// ==================================================================
// Timing
`define QBS_SYS_PERIOD_NS   10
`define QBS_DLL_STOP_NS     30
`define QBS_DLL_STOP_CYC    ((`QBS_DLL_STOP_NS + `QBS_SYS_PERIOD_NS - 1) / `QBS_SYS_PERIOD_NS)
`define QBS_DLL_LOCK_CYC    1024
`define QBS_IMP_UPD_CYC     1024
`define QBS_STRAP_WAIT      3
`define QBS_GAP_W           16

// ==================================================================
// Reset values
`define QBS_RST_SYNC        1'b0
`define QBS_RST_OE          1'b0

`endif

/* File: src/qbs_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module qbs_fifo #(
    parameter W     = 36,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // System
    input  wire          clk_i,
    input  wire          rst_i,
    // Fill side
    input  wire          in_valid_i,
    output wire          in_ready_o,
    input  wire [W-1:0]  in_data_i,
    // Drain side
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [W-1:0]  out_data_o
);
    localparam [AW:0] FULL_CNT = DEPTH;

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0]   count_q;
    wire         push;
    wire         pop;

    assign in_ready_o  = (count_q != FULL_CNT);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem[rd_ptr_q];

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            case ({push, pop})
                2'b10:   count_q <= count_q + {{AW{1'b0}}, 1'b1};
                2'b01:   count_q <= count_q - {{AW{1'b0}}, 1'b1};
                default: count_q <= count_q;
            endcase
        end
    end
endmodule // qbs_fifo

`default_nettype wire

/* File: verification/qbs_sram_ports_sva.sv */
// Concurrent checks on the pins of the burst-of-two SRAM model.
// Assumes C and C# move with K and K#, or both stay high in single mode.
`default_nettype none

module qbs_sram_ports_sva (
    // System
    input wire logic        SYS_CLK_I,
    input wire logic        SYS_RST_I,
    // Pins in
    input wire logic        SYS_IN_POS_I,
    input wire logic        SYS_IN_NEG_I,
    input wire logic        OUT_REF_POS_I,
    input wire logic        OUT_REF_NEG_I,
    input wire logic        DLL_DISABLE_N_I,
    input wire logic        READ_PORT_SELECT_N_I,
    // Pins out
    input wire logic [17:0] RD_DATA_O,
    input wire logic        RD_DATA_OE_O,
    input wire logic        ECHO_POS_OUT_O,
    input wire logic        ECHO_NEG_OUT_O,
    input wire logic        DLL_LOCKED_O,
    input wire logic        IMP_UPDATE_O,
    input wire logic        RD_FIFO_READY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Edge history
    logic        kp_q, knp_q, cp_q, cnp_q;
    logic [10:0] kcnt_q, krise_q;
    logic [5:0]  age_q, age1_q;
    wire         k_rise   = SYS_IN_POS_I & ~kp_q;
    wire         any_rise = k_rise | (SYS_IN_NEG_I & ~knp_q) | (OUT_REF_POS_I & ~cp_q) | (OUT_REF_NEG_I & ~cnp_q);
    wire         single   = OUT_REF_POS_I & OUT_REF_NEG_I;
    wire [5:0]   lat_lo   = DLL_DISABLE_N_I ? 6'h17 : 6'h0f;

    always @(posedge SYS_CLK_I) begin
        kp_q  <= SYS_IN_POS_I;
        knp_q <= SYS_IN_NEG_I;
        cp_q  <= OUT_REF_POS_I;
        cnp_q <= OUT_REF_NEG_I;
        if (SYS_RST_I) begin
            kcnt_q  <= 11'h0;
            krise_q <= 11'h0;
            age_q   <= 6'h3f;
            age1_q  <= 6'h3f;
        end else begin
            kcnt_q <= (IMP_UPDATE_O ? 11'h0 : kcnt_q) + {10'h0, k_rise};
            if (k_rise && krise_q != 11'h7ff)
                krise_q <= krise_q + 11'h1;
            // Saturates so a long idle never looks like a fresh read; the
            // older read is kept as back-to-back bursts hold the bus driven
            if (k_rise && !READ_PORT_SELECT_N_I) begin
                age_q  <= 6'h0;
                age1_q <= age_q + {5'h0, age_q != 6'h3f};
            end else begin
                age_q  <= age_q + {5'h0, age_q != 6'h3f};
                age1_q <= age1_q + {5'h0, age1_q != 6'h3f};
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    reset_out_a: assert property (
        $fell(SYS_RST_I) |-> !RD_DATA_OE_O && !DLL_LOCKED_O && !IMP_UPDATE_O && RD_FIFO_READY_O)
        else $error("outputs not quiet after reset");
    echo_ref_a: assert property (
        !single && !$past(SYS_RST_I, 8) |->
        ECHO_POS_OUT_O == $past(OUT_REF_POS_I, 3) && ECHO_NEG_OUT_O == $past(OUT_REF_NEG_I, 3))
        else $error("echo clocks do not follow output clocks");
    echo_single_a: assert property (
        single && !$past(SYS_RST_I, 8) |->
        ECHO_POS_OUT_O == $past(SYS_IN_POS_I, 3) && ECHO_NEG_OUT_O == $past(SYS_IN_NEG_I, 3))
        else $error("echo clocks do not follow input clocks");
    imp_gap_a: assert property (
        IMP_UPDATE_O |-> kcnt_q == 11'h400)
        else $error("impedance update spacing wrong");
    imp_pulse_a: assert property (
        IMP_UPDATE_O |=> !IMP_UPDATE_O [*8])
        else $error("impedance update pulse too long");
    lock_count_a: assert property (
        $rose(DLL_LOCKED_O) |-> DLL_DISABLE_N_I && krise_q >= 11'h400)
        else $error("lock came too early");
    read_start_a: assert property (
        $rose(RD_DATA_OE_O) |->
        (age_q >= lat_lo && age_q <= lat_lo + 6'h07) || (age1_q >= lat_lo && age1_q <= lat_lo + 6'h07))
        else $error("read latency wrong");
    read_float_a: assert property (
        age_q == 6'h32 |-> !RD_DATA_OE_O)
        else $error("read outputs still driven");
    data_launch_a: assert property (
        $changed(RD_DATA_O) |-> $past(any_rise, 2) || $past(any_rise, 3) || $past(any_rise, 4))
        else $error("read data changed without clock edge");

    cover property ($rose(RD_DATA_OE_O));
    cover property ($fell(DLL_LOCKED_O));
    cover property (IMP_UPDATE_O);
endmodule // qbs_sram_ports_sva

`default_nettype wire

/* File: verification/qbs_ctl_model.sv */
// Memory controller model: drives clock pairs, selects, address, write data.
// Assumes a 100 MHz clk_i; one K period is 16 of its cycles.
`default_nettype none

module qbs_ctl_model (
    // System
    input  wire logic        clk_i,
    input  wire logic        single_i,
    // Clock pins
    output var  logic        k_o,
    output var  logic        kn_o,
    output var  logic        c_o,
    output var  logic        cn_o,
    // Request pins
    output var  logic [20:0] addr_o,
    output var  logic        rps_n_o,
    output var  logic        wps_n_o,
    output var  logic [1:0]  bws_n_o,
    output var  logic [17:0] data_o,
    // Read pins
    input  wire logic [17:0] q_i,
    input  wire logic        oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] cap [$];

    // Strap: both output clocks high selects single clock mode
    assign c_o  = single_i | k_o;
    assign cn_o = single_i | kn_o;

    initial begin
        k_o = 1'b0;
        kn_o = 1'b1;
        addr_o = 21'h0;
        rps_n_o = 1'b1;
        wps_n_o = 1'b1;
        bws_n_o = 2'h3;
        data_o = 18'h0;
    end

    // ==========================================================
    // One K period; K stands still between calls
    task automatic period(input logic [57:0] r);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (i == 0) begin
                k_o     <= 1'b1;
                kn_o    <= 1'b0;
                rps_n_o <= r[57];
                wps_n_o <= r[56];
                addr_o  <= {13'h0, r[55:48]};
                data_o  <= r[21:4];
                bws_n_o <= r[1:0];
            end
            if (i == 8) begin
                k_o     <= 1'b0;
                kn_o    <= 1'b1;
                rps_n_o <= 1'b1;
                wps_n_o <= 1'b1;
                addr_o  <= {13'h0, r[47:40]};
                data_o  <= r[39:22];
                bws_n_o <= r[3:2];
            end
            // Hold time over: show the inverse, never a stale value
            if (i == 12) begin
                addr_o <= ~addr_o;
                data_o <= ~data_o;
            end
            if ((i == 5 || i == 13) && oe_i === 1'b1)
                cap.push_back(q_i);
        end
    endtask
endmodule // qbs_ctl_model

`default_nettype wire

/* File: verification/qbs_sram_ports_tb.sv */
// Self-checking bench for the burst-of-two SRAM model in three modes.
// Assumes qbs_ctl_model and qbs_sram_ports_sva are compiled before it.
`default_nettype none

module qbs_sram_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [35:0] D0  = 36'h123456789;
    localparam logic [35:0] D1  = 36'hfedcba987;
    localparam logic [35:0] MRG = D0 & 36'h007fffe00;
    localparam logic [57:0] NOP = {2'b11, 56'h5a5a5a5a5a5a5a};
    // Row: rps_n, wps_n, read addr, write addr, write burst, byte selects, read burst
    localparam logic [93:0] ROWS [7] = '{
        {2'b10, 8'h00, 8'h0a, D0, 4'h0, 36'h0},
        {2'b00, 8'h0a, 8'h0b, D1, 4'h0, D0},
        {2'b00, 8'h0b, 8'h0a, 36'h0, 4'b0110, D1},
        {2'b01, 8'h0a, 8'h0a, 36'hfffffffff, 4'h0, MRG},
        {2'b00, 8'h0b, 8'h0b, D0, 4'h0, D0},
        {2'b01, 8'h0a, 8'h0a, 36'h0, 4'h0, MRG},
        {NOP, 36'h0}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        dll_n = 1'b1;
    logic        sgl = 1'b0;
    int          mismatches = 0;
    int          n_tests = 0;
    int          imp_n = 0;
    int          j;
    wire logic   k, kn, c, cn, rps_n, wps_n, oe, lock, imp;
    wire logic [20:0] addr;
    wire logic [1:0]  bws_n;
    wire logic [17:0] wd, q;

    initial forever #5 clk = ~clk;
    always @(posedge clk) imp_n <= rst ? 0 : imp_n + int'(imp === 1'b1);

    qbs_ctl_model pm (.clk_i(clk), .single_i(sgl), .k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn), .addr_o(addr),
        .rps_n_o(rps_n), .wps_n_o(wps_n), .bws_n_o(bws_n), .data_o(wd), .q_i(q), .oe_i(oe));
    qbs_sram_ports #(.ARRAY_AW(8)) uut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .SYS_IN_POS_I(k), .SYS_IN_NEG_I(kn),
        .OUT_REF_POS_I(c), .OUT_REF_NEG_I(cn), .DLL_DISABLE_N_I(dll_n), .ADDR_I(addr), .READ_PORT_SELECT_N_I(rps_n),
        .WRITE_PORT_SELECT_N_I(wps_n), .BYTE_WRITE_SELECT_N_I(bws_n), .WR_DATA_I(wd), .RD_DATA_O(q),
        .RD_DATA_OE_O(oe), .ECHO_POS_OUT_O(), .ECHO_NEG_OUT_O(), .DLL_LOCKED_O(lock), .IMP_UPDATE_O(imp),
        .RD_FIFO_READY_O());

    // ==========================================================
    // Helpers
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic do_reset(input logic dll, input logic single);
        @(posedge clk);
        rst   <= 1'b1;
        dll_n <= dll;
        sgl   <= single;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end

    // ==========================================================
    // Main sequence
    initial begin
        for (int m = 0; m < 3; m++) begin
            do_reset(m != 1, m == 2);
            if (m == 0) begin
                repeat (1000) pm.period(NOP);
                chk(lock, 1'b0);
                repeat (30) pm.period(NOP);
                chk(lock, 1'b1);
                chk(imp_n, 1);
            end
            pm.cap.delete();
            for (int i = 0; i < 7; i++) pm.period(ROWS[i][93:36]);
            repeat (3) pm.period(NOP);
            chk(pm.cap.size(), 10);
            j = 0;
            for (int i = 0; i < 7; i++) begin
                if (ROWS[i][93] == 1'b0) begin
                    chk(pm.cap[j], ROWS[i][17:0]);
                    chk(pm.cap[j + 1], ROWS[i][35:18]);
                    j += 2;
                end
            end
            if (m == 0) begin
                repeat (40) @(posedge clk);
                chk(lock, 1'b0);
            end
        end
        tally_and_finish;
    end
endmodule // qbs_sram_ports_tb

bind qbs_sram_ports qbs_sram_ports_sva sva (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
    .SYS_IN_POS_I(SYS_IN_POS_I), .SYS_IN_NEG_I(SYS_IN_NEG_I), .OUT_REF_POS_I(OUT_REF_POS_I),
    .OUT_REF_NEG_I(OUT_REF_NEG_I), .DLL_DISABLE_N_I(DLL_DISABLE_N_I), .READ_PORT_SELECT_N_I(READ_PORT_SELECT_N_I),
    .RD_DATA_O(RD_DATA_O), .RD_DATA_OE_O(RD_DATA_OE_O), .ECHO_POS_OUT_O(ECHO_POS_OUT_O),
    .ECHO_NEG_OUT_O(ECHO_NEG_OUT_O), .DLL_LOCKED_O(DLL_LOCKED_O), .IMP_UPDATE_O(IMP_UPDATE_O),
    .RD_FIFO_READY_O(RD_FIFO_READY_O));

`default_nettype wire
